// file: core/cpc_defs.svh
// constants of the configuration port pin control block
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH

`define CPC_CLK_MHZ          125
`define CPC_CLEAR_NS         1000
`define CPC_CLEAR_CYC        ((`CPC_CLEAR_NS * `CPC_CLK_MHZ + 999) / 1000)
`define CPC_STARTUP_NS       2000
`define CPC_STARTUP_CYC      ((`CPC_STARTUP_NS * `CPC_CLK_MHZ + 999) / 1000)
`define CPC_MCLK_HALF_NS     40
`define CPC_MCLK_HALF_CYC    ((`CPC_MCLK_HALF_NS * `CPC_CLK_MHZ) / 1000)

`define CPC_MODE_SPI         3'h0
`define CPC_MODE_SPI_MULTI_BOOT_MODE        3'h1
`define CPC_MODE_SLV_SPI     3'h2
`define CPC_MODE_MSERIAL     3'h4
`define CPC_MODE_SSERIAL     3'h5
`define CPC_MODE_PARALLEL    3'h7

`define CPC_FLASH_READ_CMD   32'h0300_0000
`define CPC_FLASH_CMD_BITS   6'h20

`define CPC_TAP_IR_CAPTURE   8'h01
`define CPC_TAP_CFG_INSTR    8'h3a
`define CPC_TAP_BYPASS       8'hff

`define CPC_DATA_W           8
`define CPC_FIFO_DEPTH       16

`endif

// file: core/cpc_pkg.sv
// types of the configuration port pin control block
`default_nettype none
package cpc_pkg;

	typedef enum logic [2:0] {
		CPC_PORT_NONE, CPC_PORT_SPI, CPC_PORT_SPI_MULTI_BOOT_MODE, CPC_PORT_SLV_SPI,
		CPC_PORT_MSERIAL, CPC_PORT_SSERIAL, CPC_PORT_PAR, CPC_PORT_TAP
	} cpc_port_t;

	typedef enum logic [2:0] {
		CPC_ST_CLEAR, CPC_ST_INIT, CPC_ST_LOAD, CPC_ST_START, CPC_ST_USER
	} cpc_state_t;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR,
		TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
	} cpc_tap_t;

endpackage
`default_nettype wire

// file: core/cpc_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cpc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk_in,    // system clock
	input  wire logic             reset_n_in,    // synchronous reset, active low
	input  wire logic             clear_in,      // flush contents
	input  wire logic             in_valid_in,   // write side valid
	output logic                  in_ready_out,  // write side ready (not full)
	input  wire logic [WIDTH-1:0] in_data_in,    // write data
	output logic                  out_valid_out, // read side valid (not empty)
	input  wire logic             out_ready_in,  // read side ready
	output logic [WIDTH-1:0]      out_data_out   // read data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      wr_d;
	logic [AW:0]      rd_q;
	logic [AW:0]      rd_d;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready_out  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
		out_valid_out = (wr_q != rd_q);
		out_data_out  = mem_q[rd_q[AW-1:0]];
		push          = in_valid_in && in_ready_out;
		pop           = out_valid_out && out_ready_in;
		wr_d          = clear_in ? '0 : (push ? wr_q + 1'b1 : wr_q);
		rd_d          = clear_in ? '0 : (pop ? rd_q + 1'b1 : rd_q);
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// storage needs no reset: nothing is read before it is written
	always_ff @(posedge sys_clk_in) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

// file: core/cpc_port_ctrl.sv
// configuration port pin control: mode capture, request, ready/done, clocks, selects and test port loading
// Functional notes
// - the three mode pins are captured when the ready indicator rises and the captured value picks the mode only while no port holds the lock.
// - a low reload request starts the configuration sequence over, and the outside party pulls it low to reload.
// - readiness for configuration data is shown on an open-drain ready indicator.
// - the open-drain done indicator is released once loading has finished and startup is running.
// - after power-up the test port becomes the configuration port when its configuration instruction is loaded while no other port holds the lock.
// - in SPI, multi-boot SPI and master serial modes the device drives the master configuration clock itself.
// - the busy indicator is driven in parallel mode, and the same pin carries SPI serial data out in SPI modes.
// - serial data out, chip select out and the SPI flash select share one output pin.
// - the test state machine is clocked by the test clock, steered by mode select and loads from test data in.
// - test data is shifted out on the test data output.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"
module cpc_port_ctrl
	import cpc_pkg::*;
(
	input  wire logic                   sys_clk_in,                    // 125 MHz system clock
	input  wire logic                   reset_n_in,                    // power-up reset, sync, active low
	input  wire logic [2:0]             cfg_mode_in,                   // configuration mode pins
	input  wire logic                   reload_request_n_in,           // reload request pin, active low
	input  wire logic                   ready_for_load_n_in,           // ready pin level read back
	output logic                        ready_for_load_n_out,          // ready pin drive value
	output logic                        ready_for_load_n_oe_n_out,     // ready pin enable, low drives
	input  wire logic                   done_in,                       // done pin level read back
	output logic                        done_out,                      // done pin drive value
	output logic                        done_oe_n_out,                 // done pin enable, low drives
	input  wire logic                   slave_cfg_clock_in,            // slave configuration clock pin
	output logic                        master_clock_out,              // master configuration clock
	output logic                        master_clock_oe_n_out,         // master clock enable, low drives
	output logic                        spi_serial_out,                // busy or SPI serial data out
	input  wire logic                   primary_select_n_in,           // primary / slave SPI select, low
	input  wire logic                   second_select_n_in,            // second select or SPI hold, low
	input  wire logic                   parallel_write_enable_n_in,    // parallel write enable, low
	input  wire logic [`CPC_DATA_W-1:0] parallel_data_in,              // parallel configuration data
	input  wire logic                   serial_data_in,                // serial configuration data in
	output logic                        select_out_n_out,              // serial out / select out / flash select
	input  wire logic                   tck_in,                        // test clock pin
	input  wire logic                   tms_in,                        // test mode select pin
	input  wire logic                   tdi_in,                        // test data in pin
	output logic                        tdo_out,                       // test data out pin
	output logic [`CPC_DATA_W-1:0]      cfg_data_out,                  // configuration byte to the array
	output logic                        cfg_valid_out,                 // configuration byte valid
	input  wire logic                   cfg_ready_in,                  // array takes the byte
	input  wire logic                   load_end_in,                   // array has its last byte
	output logic [2:0]                  selected_port_out,             // locked configuration port
	output logic                        user_mode_out                  // startup finished
);
	localparam int SW = 14 + `CPC_DATA_W;

	function automatic cpc_port_t port_of(input logic [2:0] mode);
		case (mode)
			`CPC_MODE_SPI:      port_of = CPC_PORT_SPI;
			`CPC_MODE_SPI_MULTI_BOOT_MODE:     port_of = CPC_PORT_SPI_MULTI_BOOT_MODE;
			`CPC_MODE_SLV_SPI:  port_of = CPC_PORT_SLV_SPI;
			`CPC_MODE_MSERIAL:  port_of = CPC_PORT_MSERIAL;
			`CPC_MODE_SSERIAL:  port_of = CPC_PORT_SSERIAL;
			`CPC_MODE_PARALLEL: port_of = CPC_PORT_PAR;
			default:            port_of = CPC_PORT_NONE;
		endcase
	endfunction

	function automatic logic is_spi(input cpc_port_t p);
		is_spi = (p == CPC_PORT_SPI) || (p == CPC_PORT_SPI_MULTI_BOOT_MODE);
	endfunction

	function automatic logic is_master(input cpc_port_t p);
		is_master = is_spi(p) || (p == CPC_PORT_MSERIAL);
	endfunction

	function automatic cpc_tap_t tap_next(input cpc_tap_t s, input logic tms);
		case (s)
			TAP_RESET:    tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   tap_next = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
			TAP_EX1_DR:   tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
			TAP_EX2_DR:   tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   tap_next = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
			TAP_EX1_IR:   tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
			TAP_EX2_IR:   tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default:      tap_next = TAP_RESET;
		endcase
	endfunction

	// every pin passes two flip-flops before use
	logic [SW-1:0] pin_raw;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;

	assign pin_raw = {cfg_mode_in, reload_request_n_in, ready_for_load_n_in, done_in, slave_cfg_clock_in,
		primary_select_n_in, second_select_n_in, parallel_write_enable_n_in, serial_data_in,
		tck_in, tms_in, tdi_in, parallel_data_in};

	genvar g;
	generate
		for (g = 0; g < SW; g++) begin : g_sync
			always_ff @(posedge sys_clk_in) begin
				if (!reset_n_in) begin
					sync1_q[g] <= 1'b1;
					sync2_q[g] <= 1'b1;
				end else begin
					sync1_q[g] <= pin_raw[g];
					sync2_q[g] <= sync1_q[g];
				end
			end
		end
	endgenerate

	logic [2:0]             mode_s;
	logic                   reload_n_s;
	logic                   ready_rb_s;
	logic                   done_rb_s;
	logic                   sclk_s;
	logic                   psel_n_s;
	logic                   ssel_n_s;
	logic                   wen_n_s;
	logic                   sdin_s;
	logic                   tck_s;
	logic                   tms_s;
	logic                   tdi_s;
	logic [`CPC_DATA_W-1:0] pdata_s;

	assign {mode_s, reload_n_s, ready_rb_s, done_rb_s, sclk_s, psel_n_s, ssel_n_s, wen_n_s, sdin_s,
		tck_s, tms_s, tdi_s, pdata_s} = sync2_q;

	cpc_state_t             state_q, state_d;
	cpc_port_t              port_q, port_d;
	cpc_tap_t               tap_q, tap_d;
	logic [2:0]             mode_q, mode_d;
	logic [7:0]             cnt_q, cnt_d;
	logic [2:0]             edge_q, edge_d;
	logic [2:0]             div_q, div_d;
	logic                   mclk_q, mclk_d;
	logic [31:0]            cmd_q, cmd_d;
	logic [5:0]             cmd_cnt_q, cmd_cnt_d;
	logic                   so_q, so_d;
	logic                   sel_q, sel_d;
	logic                   dout_q, dout_d;
	logic [6:0]             asm_q, asm_d;
	logic [2:0]             acnt_q, acnt_d;
	logic                   push_q, push_d;
	logic [`CPC_DATA_W-1:0] pbyte_q, pbyte_d;
	logic [7:0]             ir_q, ir_d;
	logic [7:0]             ir_sh_q, ir_sh_d;
	logic                   dr_bit_q, dr_bit_d;
	logic                   tdo_q, tdo_d;

	logic                   sclk_rise;
	logic                   tck_rise;
	logic                   tck_fall;
	logic                   ready_rise;
	logic                   loading;
	logic                   bit_ev;
	logic                   bit_val;
	logic                   fifo_in_ready;

	always_comb begin
		state_d   = state_q;
		port_d    = port_q;
		tap_d     = tap_q;
		mode_d    = mode_q;
		cnt_d     = cnt_q;
		edge_d    = {sclk_s, tck_s, ready_rb_s};
		div_d     = div_q;
		mclk_d    = mclk_q;
		cmd_d     = cmd_q;
		cmd_cnt_d = cmd_cnt_q;
		so_d      = so_q;
		dout_d    = dout_q;
		asm_d     = asm_q;
		acnt_d    = acnt_q;
		push_d    = 1'b0;
		pbyte_d   = pbyte_q;
		ir_d      = ir_q;
		ir_sh_d   = ir_sh_q;
		dr_bit_d  = dr_bit_q;
		tdo_d     = tdo_q;
		bit_ev    = 1'b0;
		bit_val   = 1'b0;
		sclk_rise  = sclk_s & ~edge_q[2];
		tck_rise   = tck_s & ~edge_q[1];
		tck_fall   = ~tck_s & edge_q[1];
		ready_rise = ready_rb_s & ~edge_q[0];
		loading    = (state_q == CPC_ST_LOAD);

		// top level sequence; later states are reached only through the earlier ones
		case (state_q)
			CPC_ST_CLEAR: begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(`CPC_CLEAR_CYC - 1)) begin
					state_d = CPC_ST_INIT;
					cnt_d   = 8'h00;
				end
			end
			CPC_ST_INIT: begin
				// an outside party may hold the ready pin low to delay loading
				if (ready_rise) begin
					mode_d  = mode_s;
					state_d = CPC_ST_LOAD;
					if (port_q == CPC_PORT_NONE) begin
						port_d = port_of(mode_s);
					end
					cmd_d     = `CPC_FLASH_READ_CMD;
					so_d      = cmd_d[31];
					cmd_cnt_d = is_spi(port_of(mode_s)) && (port_q == CPC_PORT_NONE) ? 6'h00 : `CPC_FLASH_CMD_BITS;
					if (port_q != CPC_PORT_NONE) begin
						cmd_cnt_d = is_spi(port_q) ? 6'h00 : `CPC_FLASH_CMD_BITS;
					end
				end
			end
			CPC_ST_LOAD: begin
				if (load_end_in) begin
					state_d = CPC_ST_START;
				end
			end
			CPC_ST_START: begin
				// startup waits while another device still holds done low
				if (done_rb_s) begin
					cnt_d = cnt_q + 8'h01;
					if (cnt_q == 8'(`CPC_STARTUP_CYC - 1)) begin
						state_d = CPC_ST_USER;
					end
				end
			end
			CPC_ST_USER: ;
			default: state_d = CPC_ST_CLEAR;
		endcase

		// master clock: stops while the fifo is full, so a master load never overruns
		if (loading && is_master(port_q) && fifo_in_ready) begin
			div_d = div_q + 3'h1;
			if (div_q == 3'(`CPC_MCLK_HALF_CYC - 1)) begin
				div_d  = 3'h0;
				mclk_d = ~mclk_q;
				if (!mclk_q) begin
					if (cmd_cnt_q != `CPC_FLASH_CMD_BITS) begin
						cmd_cnt_d = cmd_cnt_q + 6'h01;
					end else begin
						bit_ev  = 1'b1;
						bit_val = sdin_s;
					end
				end else if (cmd_cnt_q != `CPC_FLASH_CMD_BITS) begin
					cmd_d = {cmd_q[30:0], 1'b0};
					so_d  = cmd_q[30];
				end
			end
		end

		// slave ports sample on the rising edge of the outside clock
		if (sclk_rise) begin
			case (port_q)
				CPC_PORT_SLV_SPI: if (loading && !psel_n_s && ssel_n_s) begin
					bit_ev  = 1'b1;
					bit_val = sdin_s;
				end
				CPC_PORT_SSERIAL: begin
					if (loading) begin
						bit_ev  = 1'b1;
						bit_val = sdin_s;
					end
					dout_d = sdin_s;
				end
				CPC_PORT_PAR: if (loading && !psel_n_s && !ssel_n_s && !wen_n_s) begin
					push_d  = 1'b1;
					pbyte_d = pdata_s;
				end
				default: ;
			endcase
		end

		// test access port on the sampled test clock
		if (tck_rise) begin
			tap_d = tap_next(tap_q, tms_s);
			case (tap_q)
				TAP_RESET:    ir_d = `CPC_TAP_BYPASS;
				TAP_CAP_IR:   ir_sh_d = `CPC_TAP_IR_CAPTURE;
				TAP_SHIFT_IR: ir_sh_d = {tdi_s, ir_sh_q[7:1]};
				TAP_UPD_IR: begin
					ir_d = ir_sh_q;
					// a second port is refused once any port holds the lock
					if (ir_sh_q == `CPC_TAP_CFG_INSTR && port_q == CPC_PORT_NONE) begin
						port_d = CPC_PORT_TAP;
					end
				end
				TAP_CAP_DR:   dr_bit_d = 1'b0;
				TAP_SHIFT_DR: begin
					dr_bit_d = tdi_s;
					if (ir_q == `CPC_TAP_CFG_INSTR && port_q == CPC_PORT_TAP && loading) begin
						bit_ev  = 1'b1;
						bit_val = tdi_s;
					end
				end
				default: ;
			endcase
		end
		if (tck_fall) begin
			tdo_d = (tap_q == TAP_SHIFT_IR) ? ir_sh_q[0] : ((tap_q == TAP_SHIFT_DR) ? dr_bit_q : 1'b0);
		end

		// serial bits gather msb first; a byte that meets a full fifo is lost
		if (bit_ev) begin
			asm_d  = {asm_q[5:0], bit_val};
			acnt_d = acnt_q + 3'h1;
			if (acnt_q == 3'h7) begin
				push_d  = 1'b1;
				pbyte_d = {asm_q, bit_val};
			end
		end

		case (port_q)
			CPC_PORT_SPI, CPC_PORT_SPI_MULTI_BOOT_MODE:         sel_d = ~loading;
			CPC_PORT_MSERIAL, CPC_PORT_SSERIAL: sel_d = dout_d;
			CPC_PORT_PAR:                        sel_d = ~(state_d == CPC_ST_START || state_d == CPC_ST_USER);
			default:                             sel_d = 1'b1;
		endcase

		// a reload request resets the sequence, counters, byte assembly and master clock, but not the port lock or the test access port
		if (!reload_n_s) begin
			state_d   = CPC_ST_CLEAR;
			cnt_d     = 8'h00;
			asm_d     = 7'h00;
			acnt_d    = 3'h0;
			push_d    = 1'b0;
			mclk_d    = 1'b0;
			div_d     = 3'h0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			state_q   <= CPC_ST_CLEAR;
			port_q    <= CPC_PORT_NONE;
			tap_q     <= TAP_RESET;
			mode_q    <= 3'h0;
			cnt_q     <= 8'h00;
			edge_q    <= 3'h7;
			div_q     <= 3'h0;
			mclk_q    <= 1'b0;
			cmd_q     <= 32'h0000_0000;
			cmd_cnt_q <= 6'h00;
			so_q      <= 1'b0;
			sel_q     <= 1'b1;
			dout_q    <= 1'b0;
			asm_q     <= 7'h00;
			acnt_q    <= 3'h0;
			push_q    <= 1'b0;
			pbyte_q   <= 8'h00;
			ir_q      <= `CPC_TAP_BYPASS;
			ir_sh_q   <= 8'h00;
			dr_bit_q  <= 1'b0;
			tdo_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			port_q    <= port_d;
			tap_q     <= tap_d;
			mode_q    <= mode_d;
			cnt_q     <= cnt_d;
			edge_q    <= edge_d;
			div_q     <= div_d;
			mclk_q    <= mclk_d;
			cmd_q     <= cmd_d;
			cmd_cnt_q <= cmd_cnt_d;
			so_q      <= so_d;
			sel_q     <= sel_d;
			dout_q    <= dout_d;
			asm_q     <= asm_d;
			acnt_q    <= acnt_d;
			push_q    <= push_d;
			pbyte_q   <= pbyte_d;
			ir_q      <= ir_d;
			ir_sh_q   <= ir_sh_d;
			dr_bit_q  <= dr_bit_d;
			tdo_q     <= tdo_d;
		end
	end

	cpc_fifo #(
		.WIDTH (`CPC_DATA_W),
		.DEPTH (`CPC_FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.reset_n_in    (reset_n_in),
		.clear_in      (state_q == CPC_ST_CLEAR),
		.in_valid_in   (push_q),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (pbyte_q),
		.out_valid_out (cfg_valid_out),
		.out_ready_in  (cfg_ready_in),
		.out_data_out  (cfg_data_out)
	);

	assign ready_for_load_n_out      = 1'b0;
	assign ready_for_load_n_oe_n_out = (state_q != CPC_ST_CLEAR);
	assign done_out                  = 1'b0;
	assign done_oe_n_out             = (state_q == CPC_ST_START) || (state_q == CPC_ST_USER);
	assign master_clock_out          = mclk_q;
	assign master_clock_oe_n_out     = ~is_master(port_q);
	assign spi_serial_out            = is_spi(port_q) ? so_q : ((port_q == CPC_PORT_PAR) && !fifo_in_ready);
	assign select_out_n_out          = sel_q;
	assign tdo_out                   = tdo_q;
	assign selected_port_out         = port_q;
	assign user_mode_out             = (state_q == CPC_ST_USER);
endmodule
`default_nettype wire

// file: tb/cpc_chk_sva.sv
// concurrent checks on the configuration port pin control ports
`timescale 1ns/1ps
`default_nettype none
module cpc_chk (
	input wire logic       sys_clk_in,                // system clock
	input wire logic       reset_n_in,                // sync reset, low
	input wire logic       reload_request_n_in,       // reload request, low
	input wire logic       ready_for_load_n_oe_n_out, // ready pin enable
	input wire logic       done_oe_n_out,             // done pin enable
	input wire logic       master_clock_out,          // master clock
	input wire logic       master_clock_oe_n_out,     // master clock enable
	input wire logic [2:0] selected_port_out,         // locked port
	input wire logic       user_mode_out,             // startup over
	input wire logic       cfg_valid_out,             // byte valid
	input wire logic       cfg_ready_in,              // byte taken
	input wire logic [7:0] cfg_data_out               // byte to the array
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	// two sync stages plus the state register, with a little margin
	reload_clear_a: assert property (!reload_request_n_in [*5] |-> !ready_for_load_n_oe_n_out && !done_oe_n_out)
		else $error("reload did not restart the sequence");
	done_order_a: assert property ($rose(done_oe_n_out) |-> ready_for_load_n_oe_n_out)
		else $error("done released while ready still held");
	port_lock_a: assert property (selected_port_out != 3'h0 |=> $stable(selected_port_out))
		else $error("locked port changed");
	capture_ready_a: assert property ($changed(selected_port_out) && !(selected_port_out inside {3'h0, 3'h7})
		|-> ready_for_load_n_oe_n_out)
		else $error("mode captured while ready held low");
	mclk_enable_a: assert property ($stable(selected_port_out)
		|-> master_clock_oe_n_out == !(selected_port_out inside {3'h1, 3'h2, 3'h4}))
		else $error("master clock enable wrong for port");
	mclk_half_a: assert property ($rose(master_clock_out) |-> master_clock_out [*5])
		else $error("master clock high phase too short");
	byte_hold_a: assert property (cfg_valid_out && !cfg_ready_in |=> cfg_valid_out && $stable(cfg_data_out))
		else $error("byte dropped before taken");
	user_done_a: assert property (user_mode_out |-> done_oe_n_out && ready_for_load_n_oe_n_out)
		else $error("user mode with done held");
endmodule
bind cpc_port_ctrl cpc_chk chk (
	.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reload_request_n_in(reload_request_n_in),
	.ready_for_load_n_oe_n_out(ready_for_load_n_oe_n_out), .done_oe_n_out(done_oe_n_out),
	.master_clock_out(master_clock_out), .master_clock_oe_n_out(master_clock_oe_n_out),
	.selected_port_out(selected_port_out), .user_mode_out(user_mode_out), .cfg_valid_out(cfg_valid_out),
	.cfg_ready_in(cfg_ready_in), .cfg_data_out(cfg_data_out)
);
`default_nettype wire

// file: tb/cpc_host_model.sv
// host model: slave clock, serial and parallel data, open-drain pin levels
`timescale 1ns/1ps
`default_nettype none
module cpc_host_model (
	input  wire logic rdy_oe_n_in,  // device pulls ready low when low
	input  wire logic done_oe_n_in, // device pulls done low when low
	output logic      rdy_pin_out,  // ready pin level
	output logic      done_pin_out, // done pin level
	output logic      sclk_out,     // slave configuration clock
	output logic      sdata_out,    // serial data
	output logic      psel_n_out,   // primary select
	output logic      ssel_n_out,   // second select or hold
	output logic      wr_n_out,     // parallel write enable
	output logic [7:0] pdata_out    // parallel data
);
	// pull-ups: a released pin reads high
	assign rdy_pin_out = rdy_oe_n_in;
	assign done_pin_out = done_oe_n_in;
	initial begin
		{sclk_out, sdata_out, psel_n_out, ssel_n_out, wr_n_out} = 5'h0e;
		pdata_out = 8'h00;
	end
	// clock runs only within a frame, 125 ns period
	task automatic bit_clk(input logic b);
		sdata_out = b;
		#31;
		sclk_out = 1'b1;
		#62.5;
		sclk_out = 1'b0;
		#31.5;
	endtask
	task automatic send_serial(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) bit_clk(v[i]);
		sdata_out = ~sdata_out;
	endtask
	task automatic send_par(input logic [7:0] v);
		{psel_n_out, ssel_n_out, wr_n_out} = 3'h0;
		pdata_out = v;
		bit_clk(1'b0);
		{psel_n_out, ssel_n_out, wr_n_out} = 3'h7;
		pdata_out = ~v;
		#8;
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the configuration port pin control block
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"
module tb;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] mode = `CPC_MODE_SSERIAL;
	logic       rel_n = 1'b1;
	logic       take = 1'b0;
	logic       lend = 1'b0;
	logic       rdy_oe_n, done_oe_n, rdy_pin, done_pin, sclk, sdata, psel_n, ssel_n, wr_n;
	logic       mclk, mclk_oe_n, sio, sel_o, vld, user;
	logic [7:0] pdata, dout;
	logic [2:0] port;
	logic       tck = 1'b0, tms = 1'b1, tdi = 1'b1, tdo, rdy_lvl, done_lvl;
	int         err_total = 0;
	int         n_compared = 0;
	int         cycles = 0;
	always #4 clk = ~clk;
	cpc_host_model host (.rdy_oe_n_in(rdy_oe_n), .done_oe_n_in(done_oe_n), .rdy_pin_out(rdy_pin),
		.done_pin_out(done_pin), .sclk_out(sclk), .sdata_out(sdata), .psel_n_out(psel_n), .ssel_n_out(ssel_n),
		.wr_n_out(wr_n), .pdata_out(pdata));
	cpc_port_ctrl dut (.sys_clk_in(clk), .reset_n_in(rst_n), .cfg_mode_in(mode), .reload_request_n_in(rel_n),
		.ready_for_load_n_in(rdy_pin), .ready_for_load_n_out(rdy_lvl), .ready_for_load_n_oe_n_out(rdy_oe_n),
		.done_in(done_pin), .done_out(done_lvl), .done_oe_n_out(done_oe_n), .slave_cfg_clock_in(sclk),
		.master_clock_out(mclk), .master_clock_oe_n_out(mclk_oe_n), .spi_serial_out(sio),
		.primary_select_n_in(psel_n), .second_select_n_in(ssel_n), .parallel_write_enable_n_in(wr_n),
		.parallel_data_in(pdata), .serial_data_in(sdata), .select_out_n_out(sel_o), .tck_in(tck),
		.tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .cfg_data_out(dout), .cfg_valid_out(vld),
		.cfg_ready_in(take), .load_end_in(lend), .selected_port_out(port), .user_mode_out(user));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_valid(input int lim);
		int k;
		k = 0;
		while (vld !== 1'b1 && k < lim) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic power_up(input logic [2:0] m);
		rst_n = 1'b0;
		mode = m;
		cyc(3);
		rst_n = 1'b1;
		cyc(100);
		chk("ready held in clear", 1'b0, rdy_oe_n);
		chk("pin drive levels", 2'h0, {rdy_lvl, done_lvl});
		cyc(26);
		chk("ready released", 1'b1, rdy_oe_n);
		// loading starts three cycles after release; the master clock first rises five later
		cyc(3);
	endtask
	task automatic t_serial;
		power_up(`CPC_MODE_SSERIAL);
		chk("slave serial port", 3'h5, port);
		chk("no master clock", 1'b1, mclk_oe_n);
		host.send_serial(8'ha5);
		wait_valid(40);
		chk("serial byte", 8'ha5, dout);
		chk("done held in load", 1'b0, done_oe_n);
		$display("test serial done");
	endtask
	task automatic t_reload;
		take = 1'b1;
		rel_n = 1'b0;
		cyc(10);
		take = 1'b0;
		chk("reload holds ready", 1'b0, rdy_oe_n);
		mode = `CPC_MODE_PARALLEL;
		rel_n = 1'b1;
		cyc(140);
		chk("port stays locked", 3'h5, port);
		lend = 1'b1;
		cyc(1);
		lend = 1'b0;
		cyc(4);
		chk("done released", 1'b1, done_oe_n);
		cyc(260);
		chk("user mode", 1'b1, user);
		$display("test reload done");
	endtask
	task automatic t_par;
		power_up(`CPC_MODE_PARALLEL);
		chk("parallel port", 3'h6, port);
		for (int i = 0; i < 16; i++) host.send_par(8'h10 + 8'(i));
		cyc(4);
		chk("busy when full", 1'b1, sio);
		host.send_par(8'hee);
		cyc(1);
		take = 1'b1;
		for (int i = 0; i < 16; i++) begin
			wait_valid(8);
			chk("parallel byte", 8'h10 + 8'(i), dout);
			cyc(1);
		end
		cyc(4);
		chk("fifo empty", 1'b0, vld);
		take = 1'b0;
		$display("test parallel done");
	endtask
	task automatic t_spi;
		logic [31:0] cmd;
		cmd = 32'h0;
		power_up(`CPC_MODE_SPI);
		chk("master clock driven", 1'b0, mclk_oe_n);
		for (int i = 0; i < 32; i++) begin
			@(posedge mclk);
			#1;
			cmd = {cmd[30:0], sio};
		end
		chk("flash command", `CPC_FLASH_READ_CMD, cmd);
		chk("flash select low", 1'b0, sel_o);
		$display("test spi done");
	endtask
	task automatic tap_clk(input logic s, input logic d);
		tms = s;
		tdi = d;
		cyc(4);
		tck = 1'b1;
		cyc(4);
		tck = 1'b0;
		cyc(4);
	endtask
	task automatic t_tap;
		logic [7:0] v;
		v = `CPC_TAP_CFG_INSTR;
		power_up(3'h3);
		chk("reserved mode no port", 3'h0, port);
		tap_clk(1'b0, 1'b1);
		tap_clk(1'b1, 1'b1);
		tap_clk(1'b1, 1'b1);
		tap_clk(1'b0, 1'b1);
		tap_clk(1'b0, 1'b1);
		chk("ir capture out", 1'b1, tdo);
		for (int i = 0; i < 8; i++) tap_clk(i == 7, v[i]);
		tap_clk(1'b1, 1'b1);
		tap_clk(1'b0, 1'b1);
		chk("test port locked", 3'h7, port);
		tap_clk(1'b1, 1'b1);
		tap_clk(1'b0, 1'b1);
		tap_clk(1'b0, 1'b1);
		v = 8'h5c;
		for (int i = 7; i >= 0; i--) tap_clk(i == 0, v[i]);
		wait_valid(8);
		chk("test port byte", 8'h5c, dout);
		$display("test tap done");
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			test_done;
		end
	end
	initial begin
		t_serial;
		t_reload;
		t_par;
		t_spi;
		t_tap;
		test_done;
	end
endmodule
`default_nettype wire
